// file: hdl/bfq_mem.sv
// queue storage with registered read data
`timescale 1ns/1ns
module bfq_mem
	import bfq_pkg::*;
#(
	parameter int DATA_W = DATA_W_DEF,
	parameter int AW     = 8
) (
	input  wire logic              ref_clk,
	input  wire logic              wr_en,
	input  wire logic [AW-1:0]     wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [AW-1:0]     rd_addr,
	output logic      [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] store [0:(1<<AW)-1];

	// write port
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end

	// read port, always looking at the read pointer
	always_ff @(posedge ref_clk) begin
		rd_data <= store[rd_addr];
	end

endmodule : bfq_mem

// file: hdl/bfq_pin_sync.sv
// three-stage sampler for pins from outside the reference clock domain
`timescale 1ns/1ns
module bfq_pin_sync
	import bfq_pkg::*;
#(
	parameter int W = 1
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sampled,
	output logic      [W-1:0] stable
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;

	// stage1 feeds stage2 only so metastability can settle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1  <= '0;
			stage2  <= '0;
			sampled <= '0;
		end else begin
			stage1  <= pin;
			stage2  <= stage1;
			sampled <= stage2;
		end
	end

	// a change counts once stages two and three agree
	assign stable = ~(stage2 ^ sampled);

endmodule : bfq_pin_sync

// file: hdl/bfq_pkg.sv
// shared constants for the bidirectional two-queue buffer
package bfq_pkg;

	// ---------------------------------------------------------------
	// widths and sizes
	// ---------------------------------------------------------------
	localparam int DATA_W_DEF = 36;
	localparam int DEPTH_DEF  = 256;

	// ---------------------------------------------------------------
	// sampled pin bundle, one per port: {clk, cs, dir, en, mb, data}
	// ---------------------------------------------------------------
	localparam int PIN_W   = DATA_W_DEF + 5;
	localparam int PIN_MB  = DATA_W_DEF;
	localparam int PIN_EN  = DATA_W_DEF + 1;
	localparam int PIN_DIR = DATA_W_DEF + 2;
	localparam int PIN_CS  = DATA_W_DEF + 3;
	localparam int PIN_CLK = DATA_W_DEF + 4;

	// misc pins: {queue2_reset_n, queue1_reset_n, flag_select1, flag_select0}
	localparam int MS_W    = 4;
	localparam int MS_FS0  = 0;
	localparam int MS_QUEUE1_RESET_N = 2;

	// ---------------------------------------------------------------
	// flag select codes and preset offsets
	// ---------------------------------------------------------------
	localparam logic [1:0] FS_64   = 2'h3;
	localparam logic [1:0] FS_16   = 2'h2;
	localparam logic [1:0] FS_8    = 2'h1;
	localparam logic [1:0] FS_PROG = 2'h0;
	localparam int OFS_64 = 64;
	localparam int OFS_16 = 16;
	localparam int OFS_8  = 8;

	// ---------------------------------------------------------------
	// reset values and counts
	// ---------------------------------------------------------------
	localparam logic       RST_IR     = 1'b0;
	localparam logic       RST_OR     = 1'b0;
	localparam logic       RST_AE_N   = 1'b0;
	localparam logic       RST_AF_N   = 1'b1;
	localparam logic       RST_MBF_N  = 1'b1;
	localparam logic [1:0] IR_WAIT    = 2'h2;
	localparam logic [1:0] PIN_FILL   = 2'h3;    // edges to fill the sampler

	// offset programming sequence from port a
	typedef enum logic [2:0] {
		OFS_RUN, OFS_Y1, OFS_X1, OFS_Y2, OFS_X2
	} bfq_prog_t;

endpackage : bfq_pkg

// file: hdl/bfq_top.sv
// bidirectional two-queue buffer with mailboxes and programmable flags
`timescale 1ns/1ns
module bfq_top
	import bfq_pkg::*;
#(
	parameter int DEPTH  = DEPTH_DEF,
	parameter int DATA_W = DATA_W_DEF
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              port_a_clock,
	input  wire logic              port_a_select_n,
	input  wire logic              port_a_write_not_read,
	input  wire logic              port_a_enable,
	input  wire logic              port_a_mailbox_select,
	input  wire logic [DATA_W-1:0] port_a_data_in,
	output logic      [DATA_W-1:0] port_a_data_out,
	output logic                   port_a_data_oe,
	input  wire logic              port_b_clock,
	input  wire logic              port_b_select_n,
	input  wire logic              port_b_read_not_write,
	input  wire logic              port_b_enable,
	input  wire logic              port_b_mailbox_select,
	input  wire logic [DATA_W-1:0] port_b_data_in,
	output logic      [DATA_W-1:0] port_b_data_out,
	output logic                   port_b_data_oe,
	input  wire logic              flag_select0,
	input  wire logic              flag_select1,
	input  wire logic              queue1_reset_n,
	input  wire logic              queue2_reset_n,
	output logic                   a_input_ready,
	output logic                   a_output_ready,
	output logic                   a_almost_empty_n,
	output logic                   a_almost_full_n,
	output logic                   b_input_ready,
	output logic                   b_output_ready,
	output logic                   b_almost_empty_n,
	output logic                   b_almost_full_n,
	output logic                   a_to_b_mail_flag_n,
	output logic                   b_to_a_mail_flag_n
);
	localparam int AW = $clog2(DEPTH);
	localparam int PW = AW + 1;
	typedef logic [PW-1:0] bfq_ptr_t;
	localparam bfq_ptr_t DEPTH_P = bfq_ptr_t'(DEPTH);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// words held in memory between two pointers
	function automatic bfq_ptr_t bfq_fill(input bfq_ptr_t w,
		input bfq_ptr_t r);
		bfq_fill = w - r;
	endfunction : bfq_fill

	// preset offset chosen by the flag select pins
	function automatic logic [AW-1:0] bfq_preset(input logic [1:0] fs);
		case (fs)
			FS_64:   bfq_preset = AW'(OFS_64);
			FS_16:   bfq_preset = AW'(OFS_16);
			default: bfq_preset = AW'(OFS_8);
		endcase
	endfunction : bfq_preset

	// ---------------------------------------------------------------
	// reset release and pin sampling
	// ---------------------------------------------------------------
	logic [1:0]        rst_pipe;
	logic              rst_sync_n;
	logic [PIN_W-1:0]  pa_q;
	logic [PIN_W-1:0]  pa_st;
	logic [PIN_W-1:0]  pb_q;
	logic [PIN_W-1:0]  pb_st;
	logic [MS_W-1:0]   ms_q;
	logic [MS_W-1:0]   ms_st;
	logic [1:0]        pin_age;
	logic              pins_ok;

	// two-flop release of the global reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe[1];

	// sampled pins show reset zeros until the pipeline has filled
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			pin_age <= 2'h0;
		end else if (pin_age != PIN_FILL) begin
			pin_age <= pin_age + 2'h1;
		end
	end
	assign pins_ok = (pin_age == PIN_FILL);

	bfq_pin_sync #(.W(PIN_W)) u_sync_a (
		.ref_clk (ref_clk),
		.rst_n   (rst_sync_n),
		.pin     ({port_a_clock, port_a_select_n, port_a_write_not_read,
			port_a_enable, port_a_mailbox_select, port_a_data_in}),
		.sampled (pa_q),
		.stable  (pa_st)
	);
	bfq_pin_sync #(.W(PIN_W)) u_sync_b (
		.ref_clk (ref_clk),
		.rst_n   (rst_sync_n),
		.pin     ({port_b_clock, port_b_select_n, port_b_read_not_write,
			port_b_enable, port_b_mailbox_select, port_b_data_in}),
		.sampled (pb_q),
		.stable  (pb_st)
	);
	bfq_pin_sync #(.W(MS_W)) u_sync_misc (
		.ref_clk (ref_clk),
		.rst_n   (rst_sync_n),
		.pin     ({queue2_reset_n, queue1_reset_n, flag_select1,
			flag_select0}),
		.sampled (ms_q),
		.stable  (ms_st)
	);

	// ---------------------------------------------------------------
	// filtered levels and edge events
	// ---------------------------------------------------------------
	logic       clk_a_lvl;
	logic       clk_b_lvl;
	logic [1:0] qrst_lvl;
	logic       edge_a;
	logic       edge_b;
	logic [1:0] qrst_rise;
	logic [1:0] q_rst;
	logic [1:0] fs;

	// levels change only once the last two stages agree
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			clk_a_lvl <= 1'b0;
			clk_b_lvl <= 1'b0;
			qrst_lvl  <= 2'h0;
		end else begin
			if (pa_st[PIN_CLK]) clk_a_lvl <= pa_q[PIN_CLK];
			if (pb_st[PIN_CLK]) clk_b_lvl <= pb_q[PIN_CLK];
			for (int i = 0; i < 2; i++) begin
				if (ms_st[MS_QUEUE1_RESET_N+i]) qrst_lvl[i] <= ms_q[MS_QUEUE1_RESET_N+i];
			end
		end
	end

	assign edge_a = pa_st[PIN_CLK] & pa_q[PIN_CLK] & ~clk_a_lvl;
	assign edge_b = pb_st[PIN_CLK] & pb_q[PIN_CLK] & ~clk_b_lvl;
	assign qrst_rise = ms_st[MS_QUEUE1_RESET_N+:2] & ms_q[MS_QUEUE1_RESET_N+:2] & ~qrst_lvl;
	assign q_rst = ~qrst_lvl;
	assign fs = ms_q[MS_FS0+:2];

	// ---------------------------------------------------------------
	// port decode
	// ---------------------------------------------------------------
	logic a_go;
	logic b_go;
	logic a_fifo_wr;
	logic a_fifo_rd;
	logic a_mail_wr;
	logic a_mail_rd;
	logic b_fifo_wr;
	logic b_fifo_rd;
	logic b_mail_wr;
	logic b_mail_rd;

	// enable low blocks every read and write on that edge; the first-word load still happens
	assign a_go = edge_a & ~pa_q[PIN_CS] & pa_q[PIN_EN];
	assign b_go = edge_b & ~pb_q[PIN_CS] & pb_q[PIN_EN];
	assign a_fifo_wr = a_go & pa_q[PIN_DIR] & ~pa_q[PIN_MB];
	assign a_fifo_rd = a_go & ~pa_q[PIN_DIR] & ~pa_q[PIN_MB];
	assign a_mail_wr = a_go & pa_q[PIN_DIR] & pa_q[PIN_MB];
	assign a_mail_rd = a_go & ~pa_q[PIN_DIR] & pa_q[PIN_MB];
	assign b_fifo_wr = b_go & ~pb_q[PIN_DIR] & ~pb_q[PIN_MB];
	assign b_fifo_rd = b_go & pb_q[PIN_DIR] & ~pb_q[PIN_MB];
	assign b_mail_wr = b_go & ~pb_q[PIN_DIR] & pb_q[PIN_MB];
	assign b_mail_rd = b_go & pb_q[PIN_DIR] & pb_q[PIN_MB];

	// ---------------------------------------------------------------
	// per-queue wiring: queue 0 goes a to b, queue 1 goes b to a
	// ---------------------------------------------------------------
	logic [1:0]        wr_edge;
	logic [1:0]        rd_edge;
	logic [1:0]        wr_req;
	logic [1:0]        rd_req;
	logic [1:0]        hold_ir;
	logic [1:0]        mem_we;
	logic [DATA_W-1:0] wr_data [0:1];
	logic [DATA_W-1:0] q_out   [0:1];
	bfq_ptr_t          wptr_q  [0:1];
	bfq_ptr_t          rptr_q  [0:1];
	logic [1:0]        ir_q;
	logic [1:0]        or_q;
	logic [1:0]        ae_q;
	logic [1:0]        af_q;
	logic [1:0]        load_q;
	logic [AW-1:0]     empty_off [0:1];
	logic [AW-1:0]     full_off  [0:1];
	bfq_prog_t         prog_st;
	logic              prog;

	assign wr_edge = {edge_b, edge_a};
	assign rd_edge = {edge_a, edge_b};
	assign wr_req  = {b_fifo_wr, a_fifo_wr};
	assign rd_req  = {a_fifo_rd, b_fifo_rd};
	assign wr_data[0] = pa_q[DATA_W-1:0];
	assign wr_data[1] = pb_q[DATA_W-1:0];
	assign prog = (prog_st != OFS_RUN);
	// port b stays closed until the offsets are programmed
	assign hold_ir = {prog, 1'b0};
	// programming writes do not reach memory
	assign mem_we[0] = wr_req[0] & ir_q[0] & ~prog;
	assign mem_we[1] = wr_req[1] & ir_q[1];

	for (genvar q = 0; q < 2; q++) begin : g_q
		bfq_ptr_t          wptr;
		bfq_ptr_t          rptr;
		bfq_ptr_t          rptr_s1;
		bfq_ptr_t          wptr_s1;
		bfq_ptr_t          wptr_s2;
		bfq_ptr_t          next_wptr;
		bfq_ptr_t          next_rptr;
		logic [1:0]        wait_cnt;
		logic              ir;
		logic              af_n;
		logic              orf;
		logic              ae_n;
		logic              load;
		logic [DATA_W-1:0] mem_rd;
		logic [DATA_W-1:0] out_reg;

		bfq_mem #(.DATA_W(DATA_W), .AW(AW)) u_mem (
			.ref_clk (ref_clk),
			.wr_en   (mem_we[q]),
			.wr_addr (wptr[AW-1:0]),
			.wr_data (wr_data[q]),
			.rd_addr (rptr[AW-1:0]),
			.rd_data (mem_rd)
		);

		assign next_wptr = wptr + bfq_ptr_t'(mem_we[q]);
		// load when a synced word waits and the output is free or read
		assign load = rd_edge[q] && (wptr_s2 != rptr)
			&& (!orf || rd_req[q]);
		assign next_rptr = rptr + bfq_ptr_t'(load);

		// writing side: pointer, read-pointer sync, ir and af
		always_ff @(posedge ref_clk or negedge rst_sync_n) begin
			if (!rst_sync_n) begin
				wptr     <= '0;
				rptr_s1  <= '0;
				wait_cnt <= 2'h0;
				ir       <= RST_IR;
				af_n     <= RST_AF_N;
			end else if (q_rst[q]) begin
				wptr     <= '0;
				rptr_s1  <= '0;
				wait_cnt <= 2'h0;
				ir       <= RST_IR;
				af_n     <= RST_AF_N;
			end else if (wr_edge[q]) begin
				wptr    <= next_wptr;
				rptr_s1 <= rptr;
				if (wait_cnt != IR_WAIT) wait_cnt <= wait_cnt + 2'h1;
				// second stage: flag built from the captured pointer
				ir <= (wait_cnt != 2'h0) && !hold_ir[q]
					&& (bfq_fill(next_wptr, rptr_s1) != DEPTH_P);
				af_n <= bfq_fill(next_wptr, rptr_s1)
					< (DEPTH_P - bfq_ptr_t'(full_off[q]));
			end
		end

		// reading side: write-pointer sync, or and ae
		always_ff @(posedge ref_clk or negedge rst_sync_n) begin
			if (!rst_sync_n) begin
				rptr    <= '0;
				wptr_s1 <= '0;
				wptr_s2 <= '0;
				orf     <= RST_OR;
				ae_n    <= RST_AE_N;
			end else if (q_rst[q]) begin
				rptr    <= '0;
				wptr_s1 <= '0;
				wptr_s2 <= '0;
				orf     <= RST_OR;
				ae_n    <= RST_AE_N;
			end else if (rd_edge[q]) begin
				// a write in this same cycle is caught next edge
				wptr_s1 <= wptr;
				wptr_s2 <= wptr_s1;
				rptr    <= next_rptr;
				if (load) begin
					orf <= 1'b1;
				end else if (rd_req[q] && orf) begin
					orf <= 1'b0;
				end
				ae_n <= bfq_fill(wptr_s2, next_rptr)
					> bfq_ptr_t'(empty_off[q]);
			end
		end

		// output register holds its word until the next load
		always_ff @(posedge ref_clk or negedge rst_sync_n) begin
			if (!rst_sync_n) begin
				out_reg <= '0;
			end else if (load) begin
				out_reg <= mem_rd;
			end
		end

		assign wptr_q[q] = wptr;
		assign rptr_q[q] = rptr;
		assign ir_q[q]   = ir;
		assign or_q[q]   = orf;
		assign ae_q[q]   = ae_n;
		assign af_q[q]   = af_n;
		assign load_q[q] = load;
		assign q_out[q]  = out_reg;
	end

	// flag ports, each from its queue's flip-flop
	assign a_input_ready    = ir_q[0];
	assign a_almost_full_n  = af_q[0];
	assign b_output_ready   = or_q[0];
	assign b_almost_empty_n = ae_q[0];
	assign b_input_ready    = ir_q[1];
	assign b_almost_full_n  = af_q[1];
	assign a_output_ready   = or_q[1];
	assign a_almost_empty_n = ae_q[1];

	// ---------------------------------------------------------------
	// almost-flag offsets
	// ---------------------------------------------------------------
	// programming sequence, entered when both queues leave reset at 00
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			prog_st <= OFS_RUN;
		end else if (qrst_rise == 2'h3 && fs == FS_PROG) begin
			prog_st <= OFS_Y1;
		end else if (wr_req[0] && ir_q[0]) begin
			case (prog_st)
				OFS_Y1:  prog_st <= OFS_X1;
				OFS_X1:  prog_st <= OFS_Y2;
				OFS_Y2:  prog_st <= OFS_X2;
				default: prog_st <= OFS_RUN;
			endcase
		end
	end

	// preset on reset release, or loaded by programming writes
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			for (int i = 0; i < 2; i++) begin
				empty_off[i] <= '0;
				full_off[i]  <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (qrst_rise[i] && fs != FS_PROG) begin
					empty_off[i] <= bfq_preset(fs);
					full_off[i]  <= bfq_preset(fs);
				end
			end
			if (wr_req[0] && ir_q[0]) begin
				case (prog_st)
					OFS_Y1:  full_off[0]  <= pa_q[AW-1:0];
					OFS_X1:  empty_off[0] <= pa_q[AW-1:0];
					OFS_Y2:  full_off[1]  <= pa_q[AW-1:0];
					OFS_X2:  empty_off[1] <= pa_q[AW-1:0];
					default: ;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// mailboxes
	// ---------------------------------------------------------------
	logic [DATA_W-1:0] mailbox_a_to_b;
	logic [DATA_W-1:0] mailbox_b_to_a;

	// mail data; a write lowers the flag, a far read raises it
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			mailbox_a_to_b     <= '0;
			mailbox_b_to_a     <= '0;
			a_to_b_mail_flag_n <= RST_MBF_N;
			b_to_a_mail_flag_n <= RST_MBF_N;
		end else begin
			if (a_mail_wr) mailbox_a_to_b <= pa_q[DATA_W-1:0];
			if (b_mail_wr) mailbox_b_to_a <= pb_q[DATA_W-1:0];
			if (q_rst[0]) begin
				a_to_b_mail_flag_n <= RST_MBF_N;
			end else if (a_mail_wr) begin
				a_to_b_mail_flag_n <= 1'b0;
			end else if (b_mail_rd) begin
				a_to_b_mail_flag_n <= 1'b1;
			end
			if (q_rst[1]) begin
				b_to_a_mail_flag_n <= RST_MBF_N;
			end else if (b_mail_wr) begin
				b_to_a_mail_flag_n <= 1'b0;
			end else if (a_mail_rd) begin
				b_to_a_mail_flag_n <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// data bus drive
	// ---------------------------------------------------------------
	// drive follows sampled select; mailbox select picks the source
	always_ff @(posedge ref_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			port_a_data_oe  <= 1'b0;
			port_b_data_oe  <= 1'b0;
			port_a_data_out <= '0;
			port_b_data_out <= '0;
		end else begin
			// no drive while the sampler still holds reset zeros
			port_a_data_oe  <= pins_ok
				& ~pa_q[PIN_CS] & ~pa_q[PIN_DIR];
			port_b_data_oe  <= pins_ok
				& ~pb_q[PIN_CS] & pb_q[PIN_DIR];
			port_a_data_out <= pa_q[PIN_MB] ? mailbox_b_to_a : q_out[1];
			port_b_data_out <= pb_q[PIN_MB] ? mailbox_a_to_b : q_out[0];
		end
	end

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_sync_n);

	sequence s_load0;
		load_q[0] && !q_rst[0];
	endsequence
	sequence s_or0_step;
		or_q[0] && rptr_q[0] == bfq_ptr_t'($past(rptr_q[0]) + 1'b1);
	endsequence

	a_bus_a_drive: assert property (
		port_a_data_oe |-> !$past(pa_q[PIN_CS]) && !$past(pa_q[PIN_DIR]))
		else $error("port a bus driven while not selected for read");
	a_bus_b_drive: assert property (
		port_b_data_oe |-> !$past(pb_q[PIN_CS]) && $past(pb_q[PIN_DIR]))
		else $error("port b bus driven while not selected for read");
	a_full_write_drop: assert property (
		(wr_req[0] && !ir_q[0] && !q_rst[0]) |=> $stable(wptr_q[0]))
		else $error("write accepted while input ready low");
	a_wptr_step: assert property (
		(!$stable(wptr_q[0]) && !$past(q_rst[0]))
		|-> wptr_q[0] == bfq_ptr_t'($past(wptr_q[0]) + 1'b1))
		else $error("write pointer moved by other than one");
	a_or_own_clock: assert property (
		!$stable(b_output_ready) |-> $past(edge_b) || $past(q_rst[0]))
		else $error("b output ready changed off its port clock");
	a_load_step: assert property (
		s_load0 |=> s_or0_step)
		else $error("output load without ready or pointer step");
	a_read_ignored: assert property (
		(rd_req[0] && !or_q[0] && !load_q[0]) |=> $stable(q_out[0]))
		else $error("output register changed on ignored read");
	a_mail_flag: assert property (
		(a_mail_wr && !q_rst[0]) |=> !a_to_b_mail_flag_n ##1 1'b1)
		else $error("mail flag not lowered after mailbox write");
	a_prog_no_store: assert property (
		(wr_req[0] && ir_q[0] && prog) |=> $stable(wptr_q[0]))
		else $error("programming write stored into queue");
	a_ir_space: assert property (
		ir_q[0] |-> bfq_fill(wptr_q[0], rptr_q[0]) < DEPTH_P)
		else $error("input ready high with queue full");

endmodule : bfq_top

// file: tb/bfq_port_model.sv
// far-side port master: clock, controls and bus of one port
`timescale 1ns/1ns
module bfq_port_model #(
	parameter int W = 36
) (
	input  wire logic         ref_clk,
	output logic              clk,
	output logic              sel_n,
	output logic              dir,
	output logic              en,
	output logic              mb,
	output logic      [W-1:0] data
);
	// idle: deselected, port clock low
	initial begin
		{clk, sel_n, dir, en, mb} = 5'h08;
		data = '0;
	end

	// one port cycle; controls held through the edge, then bus let go
	task automatic op(input logic [3:0] ctl, input logic [W-1:0] w);
		@(posedge ref_clk) #1;
		{sel_n, dir, en, mb} = ctl;
		data = w;
		repeat (4) @(posedge ref_clk) #1;
		clk = 1'b1;
		repeat (4) @(posedge ref_clk) #1;
		clk = 1'b0;
		repeat (4) @(posedge ref_clk) #1;
		en = 1'b0;
		data = ~w; // released bus never repeats the old word
	endtask : op
endmodule : bfq_port_model

// file: tb/bfq_top_tb.sv
// self-checking bench for the two-queue buffer
`timescale 1ns/1ns
module bfq_top_tb;
	import bfq_pkg::*;
	logic ref_clk, rst_n, port_a_clock, port_a_select_n, port_a_write_not_read;
	logic port_a_enable, port_a_mailbox_select, port_b_clock, port_b_select_n;
	logic port_b_read_not_write, port_b_enable, port_b_mailbox_select;
	logic flag_select0, flag_select1, queue1_reset_n, queue2_reset_n;
	logic port_a_data_oe, port_b_data_oe, a_input_ready, a_output_ready;
	logic a_almost_empty_n, a_almost_full_n, b_input_ready, b_output_ready;
	logic b_almost_empty_n, b_almost_full_n;
	logic a_to_b_mail_flag_n, b_to_a_mail_flag_n;
	logic [35:0] port_a_data_in, port_a_data_out, port_b_data_in, port_b_data_out;
	int          n_mismatch, total_checks;

	bfq_top #(.DEPTH(16)) bfq_top_inst (.*);
	bfq_port_model bfq_port_model_inst_a (.ref_clk, .clk(port_a_clock),
		.sel_n(port_a_select_n), .dir(port_a_write_not_read),
		.en(port_a_enable), .mb(port_a_mailbox_select), .data(port_a_data_in));
	bfq_port_model bfq_port_model_inst_b (.ref_clk, .clk(port_b_clock),
		.sel_n(port_b_select_n), .dir(port_b_read_not_write),
		.en(port_b_enable), .mb(port_b_mailbox_select), .data(port_b_data_in));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	always #5 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [35:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic report_and_stop;
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		repeat (4) begin
			bfq_port_model_inst_a.op(4'h8, '0);
			bfq_port_model_inst_b.op(4'h8, '0);
		end
		chk("reset flags", {a_input_ready, b_output_ready, a_almost_empty_n,
			b_almost_full_n, a_to_b_mail_flag_n}, 36'h03);
		{queue1_reset_n, queue2_reset_n} = 2'h3;
		bfq_port_model_inst_a.op(4'h8, '0);
		chk("a in ready first edge", a_input_ready, 1'b0);
		bfq_port_model_inst_a.op(4'h8, '0);
		chk("a in ready second edge", a_input_ready, 1'b1);
	endtask : t_reset

	task automatic t_fwft;
		bfq_port_model_inst_a.op(4'h6, 36'h012345678);
		bfq_port_model_inst_b.op(4'h4, '0);
		bfq_port_model_inst_b.op(4'h4, '0);
		chk("b out ready two edges", b_output_ready, 1'b0);
		bfq_port_model_inst_b.op(4'h4, '0);
		chk("b out ready three edges", b_output_ready, 1'b1);
		chk("b first word", port_b_data_out, 36'h012345678);
		chk("b bus drive", port_b_data_oe, 1'b1);
		bfq_port_model_inst_a.op(4'h6, 36'h9abcdef01);
		repeat (3) bfq_port_model_inst_b.op(4'h4, '0);
		chk("b held word", port_b_data_out, 36'h012345678);
		bfq_port_model_inst_b.op(4'h6, '0);
		chk("b read word", port_b_data_out, 36'h9abcdef01);
		bfq_port_model_inst_b.op(4'h6, '0);
		bfq_port_model_inst_b.op(4'h6, '0);
		chk("b out ready empty", b_output_ready, 1'b0);
		chk("b kept word", port_b_data_out, 36'h9abcdef01);
	endtask : t_fwft

	task automatic t_enable_mail;
		bfq_port_model_inst_a.op(4'h4, 36'h777);
		repeat (3) bfq_port_model_inst_b.op(4'h4, '0);
		chk("no op enable low", b_output_ready, 1'b0);
		bfq_port_model_inst_b.op(4'h2, 36'h0000abcde);
		bfq_port_model_inst_b.op(4'h0, '0);
		chk("b bus off writing", port_b_data_oe, 1'b0);
		repeat (3) bfq_port_model_inst_a.op(4'h0, '0);
		chk("a first word", port_a_data_out, 36'h0000abcde);
		chk("a bus drive", port_a_data_oe, 1'b1);
		bfq_port_model_inst_a.op(4'h7, 36'h5a5a5a5a5);
		chk("a bus off writing", port_a_data_oe, 1'b0);
		chk("mail ab set", a_to_b_mail_flag_n, 1'b0);
		bfq_port_model_inst_b.op(4'h7, '0);
		chk("mail ab data", port_b_data_out, 36'h5a5a5a5a5);
		chk("mail ab read", a_to_b_mail_flag_n, 1'b1);
		bfq_port_model_inst_b.op(4'h3, 36'hc3c3c3c3c);
		chk("mail ba set", b_to_a_mail_flag_n, 1'b0);
		bfq_port_model_inst_a.op(4'h3, '0);
		chk("mail ba data", port_a_data_out, 36'hc3c3c3c3c);
		chk("mail ba read", b_to_a_mail_flag_n, 1'b1);
	endtask : t_enable_mail

	task automatic t_full;
		for (int i = 0; i < 16; i++)
			bfq_port_model_inst_a.op(4'h6, 36'h100 + 36'(i));
		chk("a in ready full", a_input_ready, 1'b0);
		chk("a almost full", a_almost_full_n, 1'b0);
		bfq_port_model_inst_a.op(4'h6, 36'hbad);
		repeat (3) bfq_port_model_inst_b.op(4'h4, '0);
		chk("b ae above offset", b_almost_empty_n, 1'b1);
		bfq_port_model_inst_a.op(4'h8, '0);
		chk("a in ready one edge", a_input_ready, 1'b0);
		bfq_port_model_inst_a.op(4'h8, '0);
		chk("a in ready two edges", a_input_ready, 1'b1);
		for (int i = 1; i < 16; i++) begin
			bfq_port_model_inst_b.op(4'h6, '0);
			chk("drain word", port_b_data_out, 36'h100 + 36'(i));
		end
	endtask : t_full

	// both queues reset with select 00, offsets written from port a
	task automatic t_program;
		{queue1_reset_n, queue2_reset_n} = 2'h0;
		{flag_select1, flag_select0} = FS_PROG;
		repeat (4) begin
			bfq_port_model_inst_a.op(4'h8, '0);
			bfq_port_model_inst_b.op(4'h8, '0);
		end
		chk("b out ready reset", b_output_ready, 1'b0);
		chk("a out ready reset", a_output_ready, 1'b0);
		{queue1_reset_n, queue2_reset_n} = 2'h3;
		repeat (2) begin
			bfq_port_model_inst_a.op(4'h8, '0);
			bfq_port_model_inst_b.op(4'h8, '0);
		end
		chk("b in ready held", b_input_ready, 1'b0);
		// queue 1 full 3, empty 2; queue 2 full 4, empty 1
		bfq_port_model_inst_a.op(4'h6, 36'h3);
		bfq_port_model_inst_a.op(4'h6, 36'h2);
		bfq_port_model_inst_a.op(4'h6, 36'h4);
		bfq_port_model_inst_a.op(4'h6, 36'h1);
		repeat (3) bfq_port_model_inst_b.op(4'h4, '0);
		chk("prog no store", b_output_ready, 1'b0);
		chk("b in ready after prog", b_input_ready, 1'b1);
		repeat (3) bfq_port_model_inst_a.op(4'h6, 36'h200);
		repeat (3) bfq_port_model_inst_b.op(4'h4, '0);
		chk("b ae at offset", b_almost_empty_n, 1'b0);
		bfq_port_model_inst_a.op(4'h6, 36'h201);
		repeat (3) bfq_port_model_inst_b.op(4'h4, '0);
		chk("b ae past offset", b_almost_empty_n, 1'b1);
		for (int i = 0; i < 3; i++)
			bfq_port_model_inst_b.op(4'h2, 36'h300 + 36'(i));
		repeat (3) bfq_port_model_inst_a.op(4'h0, '0);
		chk("a out ready first", a_output_ready, 1'b1);
		chk("a ae past offset", a_almost_empty_n, 1'b1);
		bfq_port_model_inst_a.op(4'h2, '0);
		chk("a read word", port_a_data_out, 36'h301);
	endtask : t_program

	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		{flag_select1, flag_select0} = FS_8;
		{queue1_reset_n, queue2_reset_n} = 2'h0;
		repeat (12) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		t_reset();
		t_fwft();
		t_enable_mail();
		t_full();
		t_program();
		report_and_stop();
	end

	initial begin
		#100000;
		n_mismatch++;
		report_and_stop();
	end
endmodule : bfq_top_tb
